// file: verilog/dac_host.sv
`timescale 1ns/1ps
// What this block does
// - one bus word carries a full code
// - three-bit binary channel address, a to h
// - readback: select low, write high, read pulse
// - host waits wake time after sleep release
// - gain and buffer ride upper bus bits
// - host bus at least code width wide
module dac_host
	import dac_host_pkg::*;
#(
	parameter int wake_count = wake_cycles
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic chip_select_n,
	output logic write_n,
	output logic read_n,
	output logic output_transfer_n,
	output logic wipe_n,
	output logic sleep_n,
	output logic channel_addr_msb,
	output logic channel_addr_mid,
	output logic channel_addr_lsb,
	input wire logic [bus_width-1:0] data_in,
	output logic [bus_width-1:0] data_out,
	output logic data_oe
);
	// ****************************************
	// pin input synchroniser
	// ****************************************
	logic [bus_width-1:0] data_meta;
	logic [bus_width-1:0] data_sync;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_meta <= 16'h0000;
			data_sync <= 16'h0000;
		end
		else
		begin
			data_meta <= data_in;
			data_sync <= data_meta;
		end
	end

	// ****************************************
	// register state
	// ****************************************
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic aw_held;
	logic w_held;
	// low lane strobe is latched with the word, since the master may move it after the handshake
	logic w_low_lane;
	logic seq_start;
	logic [3:0] seq_op;
	logic [2:0] seq_addr;
	logic [bus_width-1:0] seq_word;
	logic seq_busy;
	logic [bus_width-1:0] captured;
	logic sync_mode;
	logic [15:0] wake_left;
	logic seq_busy_q;
	logic pending_load;
	logic seq_out_transfer_n;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == cmd_offset) || (a == mode_offset) || (a == status_offset) ||
			(a == readback_offset) || (a == pin_offset);
	endfunction

	// write channel: address and data taken in either order
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_low_lane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_low_lane <= s_axi_wstrb[0];
			end
			if (aw_held && w_held)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr) ? resp_okay : resp_slverr;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// command issue; commands while busy or waking are dropped
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seq_start <= 1'b0;
			seq_op <= 4'h0;
			seq_addr <= 3'h0;
			seq_word <= 16'h0000;
			sync_mode <= 1'b0;
			sleep_n <= 1'b1;
		end
		else
		begin
			seq_start <= 1'b0;
			if (aw_held && w_held && w_low_lane)
			begin
				if (aw_addr == cmd_offset && !seq_busy && wake_left == 16'h0000)
				begin
					seq_start <= 1'b1;
					seq_op <= w_data[op_lsb +: 4];
					seq_addr <= w_data[addr_lsb +: 3];
					seq_word <= w_data[bus_width-1:0];
				end
				if (aw_addr == mode_offset)
					sync_mode <= w_data[sync_bit];
				if (aw_addr == pin_offset)
					sleep_n <= w_data[sleep_bit];
			end
		end
	end

	// wake delay after sleep release blocks new commands
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wake_left <= 16'h0000;
		else if (aw_held && w_held && w_low_lane && aw_addr == pin_offset && w_data[sleep_bit] && !sleep_n)
			wake_left <= 16'(wake_count);
		else if (wake_left != 16'h0000)
			wake_left <= wake_left - 16'h0001;
	end

	// ****************************************
	// pin sequencer
	// ****************************************
	dac_pin_sequencer seq_inst (
		.clk(clk),
		.reset_n(reset_n),
		.start(seq_start),
		.op(seq_op),
		.addr(seq_addr),
		.word(seq_word),
		.data_sync(data_sync),
		.busy(seq_busy),
		.captured(captured),
		.chip_select_n(chip_select_n),
		.write_n(write_n),
		.read_n(read_n),
		.output_transfer_n(seq_out_transfer_n),
		.wipe_n(wipe_n),
		.channel_addr_msb(channel_addr_msb),
		.channel_addr_mid(channel_addr_mid),
		.channel_addr_lsb(channel_addr_lsb),
		.data_out(data_out),
		.data_oe(data_oe)
	);

	// synchronous mode holds the load line low throughout; the device ignores it during readback
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pending_load <= 1'b1;
		else
			pending_load <= sync_mode ? 1'b0 : seq_out_transfer_n;
	end
	assign output_transfer_n = pending_load;

	// busy tracking for status
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			seq_busy_q <= 1'b0;
		else
			seq_busy_q <= seq_busy;
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
			unique case (s_axi_araddr)
				mode_offset: s_axi_rdata <= {31'h0, sync_mode};
				status_offset: s_axi_rdata <= {30'h0, wake_left != 16'h0000, seq_busy_q | seq_busy};
				readback_offset: s_axi_rdata <= {16'h0000, captured};
				pin_offset: s_axi_rdata <= {31'h0, sleep_n};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // dac_host

// file: verilog/dac_host_pkg.sv
package dac_host_pkg;
	// ****************************************
	// software registers on the axi4-lite side
	// ****************************************
	localparam logic [7:0] cmd_offset = 8'h00;
	localparam logic [7:0] mode_offset = 8'h04;
	localparam logic [7:0] status_offset = 8'h08;
	localparam logic [7:0] readback_offset = 8'h0c;
	localparam logic [7:0] pin_offset = 8'h10;

	// ****************************************
	// command word layout
	// ****************************************
	localparam int code_width = 12;
	localparam int bus_width = 16;
	localparam int gain_bit = 12;
	localparam int buffer_bit = 13;
	localparam int op_lsb = 16;
	localparam int addr_lsb = 20;
	localparam logic [3:0] op_write = 4'h1;
	localparam logic [3:0] op_read = 4'h2;
	localparam logic [3:0] op_load = 4'h3;
	localparam logic [3:0] op_wipe = 4'h4;

	// ****************************************
	// pin and mode register bits
	// ****************************************
	localparam int sleep_bit = 0;
	localparam int sync_bit = 0;

	// ****************************************
	// strobe timing
	// ****************************************
	localparam int clk_period_ps = 4000;
	localparam int strobe_ns = 20;
	localparam int strobe_cycles = (strobe_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
	localparam int wake_ns = 5000;
	localparam int wake_cycles = (wake_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
endpackage

// file: verilog/dac_pin_sequencer.sv
`timescale 1ns/1ps
// drives one strobe cycle on the parallel pins
module dac_pin_sequencer
	import dac_host_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [3:0] op,
	input wire logic [2:0] addr,
	input wire logic [bus_width-1:0] word,
	input wire logic [bus_width-1:0] data_sync,
	output logic busy,
	output logic [bus_width-1:0] captured,
	output logic chip_select_n,
	output logic write_n,
	output logic read_n,
	output logic output_transfer_n,
	output logic wipe_n,
	output logic channel_addr_msb,
	output logic channel_addr_mid,
	output logic channel_addr_lsb,
	output logic [bus_width-1:0] data_out,
	output logic data_oe
);
	typedef enum {idle_st, setup_st, active_st, hold_st} seq_type;
	seq_type state;
	logic [15:0] count;
	logic [3:0] cur_op;

	// state and timing; each phase lasts strobe_cycles
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= idle_st;
			count <= 16'h0000;
			cur_op <= 4'h0;
		end
		else
		begin
			unique case (state)
				idle_st:
				begin
					if (start)
					begin
						state <= setup_st;
						cur_op <= op;
						count <= 16'(strobe_cycles);
					end
				end
				setup_st, active_st, hold_st:
				begin
					if (count > 16'h0001)
						count <= count - 16'h0001;
					else
					begin
						count <= 16'(strobe_cycles);
						state <= (state == setup_st) ? active_st : (state == active_st) ? hold_st : idle_st;
					end
				end
			endcase
		end
	end

	assign busy = (state != idle_st);

	// pin drive; strobes never low together, read never overlaps write
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			chip_select_n <= 1'b1;
			write_n <= 1'b1;
			read_n <= 1'b1;
			output_transfer_n <= 1'b1;
			wipe_n <= 1'b1;
			{channel_addr_msb, channel_addr_mid, channel_addr_lsb} <= 3'h0;
			data_out <= 16'h0000;
			data_oe <= 1'b0;
		end
		else
		begin
			if (state == idle_st && start)
			begin
				{channel_addr_msb, channel_addr_mid, channel_addr_lsb} <= addr;
				data_out <= word;
				data_oe <= (op == op_write);
				chip_select_n <= !(op == op_write || op == op_read);
			end
			if (state == setup_st && count == 16'h0001)
			begin
				write_n <= !(cur_op == op_write);
				read_n <= !(cur_op == op_read);
				output_transfer_n <= !(cur_op == op_load);
				wipe_n <= !(cur_op == op_wipe);
			end
			if (state == active_st && count == 16'h0001)
			begin
				// rising edge of write strobe latches the word in the device
				write_n <= 1'b1;
				read_n <= 1'b1;
				output_transfer_n <= 1'b1;
				wipe_n <= 1'b1;
			end
			if (state == hold_st && count == 16'h0001)
			begin
				chip_select_n <= 1'b1;
				data_oe <= 1'b0;
			end
		end
	end

	// readback sampled just before the read strobe rises
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			captured <= 16'h0000;
		else if (state == active_st && count == 16'h0001 && cur_op == op_read)
			captured <= data_sync;
	end
endmodule // dac_pin_sequencer

// file: sim/dac_host_props.sv
`timescale 1ns/1ps
module dac_host_props
	import dac_host_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic sleep_n,
	input wire logic channel_addr_msb,
	input wire logic channel_addr_mid,
	input wire logic channel_addr_lsb,
	input wire logic [bus_width-1:0] data_out,
	input wire logic data_oe
);
	wire logic [2:0] addr = {channel_addr_msb, channel_addr_mid, channel_addr_lsb};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ****
	// pin sequencing
	// ****
	AST_NO_DUAL_STROBE: assert property (write_n || read_n)
		else $error("both strobes low");
	AST_WRITE_FRAME: assert property ($fell(write_n) |-> !chip_select_n && read_n && data_oe)
		else $error("write strobe without frame");
	AST_WRITE_WIDTH: assert property ($fell(write_n) |-> !write_n [*5])
		else $error("write strobe too short");
	AST_WRITE_HOLD: assert property (!write_n && $past(write_n) == 1'b0 |-> $stable(data_out))
		else $error("bus word moved under strobe");
	AST_ADDR_HOLD: assert property (!write_n || !read_n |-> $stable(addr))
		else $error("address moved under strobe");
	AST_READ_FRAME: assert property ($fell(read_n) |-> !chip_select_n && write_n)
		else $error("read strobe without frame");
	AST_READ_RELEASE: assert property (!read_n |-> !data_oe && !chip_select_n)
		else $error("bus driven during read");
	AST_CS_HOLD: assert property ($rose(write_n) || $rose(read_n) |-> !chip_select_n)
		else $error("select dropped before strobe rose");
	// the wake delay keeps the select idle for a while after power returns
	AST_WAKE_QUIET: assert property ($rose(sleep_n) |-> chip_select_n [*8])
		else $error("access during wake time");
	cover property ($fell(write_n));
	cover property ($fell(read_n));
	cover property ($rose(sleep_n));
endmodule // dac_host_props

// file: sim/dac_device_model.sv
`timescale 1ns/1ps
module dac_device_model
	import dac_host_pkg::*;
(
	input wire logic chip_select_n,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic output_transfer_n,
	input wire logic wipe_n,
	input wire logic sleep_n,
	input wire logic [2:0] addr,
	input wire logic [bus_width-1:0] bus_in,
	output logic [bus_width-1:0] bus_out,
	output logic powered_down
);
	logic [code_width-1:0] in_reg [8];
	logic [code_width-1:0] dac_reg [8];
	logic [7:0] fresh;
	logic gain_in, buf_in, gain_eff, buf_eff;
	// only channels written since their last update move
	task automatic transfer();
		foreach (dac_reg[i])
			if (fresh[i])
				dac_reg[i] = in_reg[i];
		fresh = 8'h00;
		gain_eff = gain_in;
		buf_eff = buf_in;
	endtask
	// power-on state: zero, buffered, unity gain
	initial
	begin
		foreach (in_reg[i]) in_reg[i] = '0;
		foreach (dac_reg[i]) dac_reg[i] = '0;
		fresh = 8'h00;
		{gain_in, gain_eff, buf_in, buf_eff} = 4'b0011;
		bus_out = 16'h0000;
	end
	always @(posedge write_n)
		if (wipe_n && !chip_select_n && read_n)
		begin
			in_reg[addr] = bus_in[code_width-1:0];
			gain_in = bus_in[gain_bit];
			buf_in = bus_in[buffer_bit];
			fresh[addr] = 1'b1;
			if (!output_transfer_n)
				transfer();
		end
	always @(negedge output_transfer_n)
		if (wipe_n)
			transfer();
	always @(negedge wipe_n)
	begin
		foreach (in_reg[i]) in_reg[i] = '0;
		foreach (dac_reg[i]) dac_reg[i] = '0;
	end
	// undriven bus flips each change: no pull on these lines
	always @(read_n or chip_select_n or addr)
		if (!chip_select_n && !read_n && write_n)
			bus_out = 16'(dac_reg[addr]);
		else
			bus_out = ~bus_out;
	assign powered_down = !sleep_n;
endmodule // dac_device_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import dac_host_pkg::*;
	logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, chip_select_n, write_n, read_n;
	logic output_transfer_n, wipe_n, sleep_n, channel_addr_msb, channel_addr_mid, channel_addr_lsb, data_oe;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	logic [bus_width-1:0] data_in, data_out;
	int mismatches, cmp_count, cycles;
	dac_host #(.wake_count(10)) dut (.*);
	dac_device_model m (.chip_select_n, .write_n, .read_n, .output_transfer_n, .wipe_n, .sleep_n,
		.addr({channel_addr_msb, channel_addr_mid, channel_addr_lsb}), .bus_in(data_out), .bus_out(data_in),
		.powered_down());
	// ****
	// access tasks
	// ****
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// status polling: the cycle ceiling catches a stuck busy
	task automatic cmd(input logic [3:0] op, input logic [2:0] c, input logic [15:0] w);
		wr(cmd_offset, {9'h000, c, op, w});
		rv = 32'h3;
		while (rv[1:0] !== 2'b00)
			rd(status_offset);
	endtask
	task automatic rb(input logic [2:0] c, input logic [11:0] e);
		cmd(op_read, c, 16'h0000);
		rd(readback_offset);
		chk("readback", 32'(e), rv & 32'hffff);
	endtask
	task automatic end_of_test();
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	// ****
	// scenarios
	// ****
	initial
	begin
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hf};
		{mismatches, cmp_count, cycles} = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		chk("buf", 1, m.buf_eff);
		rb(3'd7, 12'h000);
		for (int c = 0; c < 8; c++)
			cmd(op_write, c[2:0], 16'h13a0 + 16'(c));
		for (int c = 0; c < 8; c++)
			chk("held", 0, m.dac_reg[c]);
		chk("gain", 0, m.gain_eff);
		cmd(op_load, 3'd0, 16'h0000);
		for (int c = 0; c < 8; c++)
			rb(c[2:0], 12'h3a0 + 12'(c));
		chk("gain", 2, {m.gain_eff, m.buf_eff});
		wr(mode_offset, 32'h1);
		chk("bresp", {30'h0, resp_okay}, {30'h0, br});
		s_axi_wstrb <= 4'h0;
		wr(mode_offset, 32'h0);
		s_axi_wstrb <= 4'hf;
		rd(mode_offset);
		chk("mode", 1, rv);
		cmd(op_write, 3'd5, 16'h0abc);
		chk("sync", 12'habc, m.dac_reg[5]);
		wr(pin_offset, 32'h0);
		rd(pin_offset);
		chk("sleep", 0, {sleep_n, rv[0]});
		wr(pin_offset, 32'h1);
		rd(status_offset);
		chk("waking", 1, rv[1]);
		cmd(op_read, 3'd5, 16'h0000);
		rd(readback_offset);
		chk("dropped", 32'h3a7, rv & 32'hffff);
		rb(3'd5, 12'habc);
		cmd(op_wipe, 3'd0, 16'h0000);
		rb(3'd5, 12'h000);
		rd(8'h40);
		chk("resp", {30'h0, resp_slverr}, {30'h0, rr});
		chk("rdata", 0, rv);
		wr(8'h40, 32'h0);
		chk("bresp", {30'h0, resp_slverr}, {30'h0, br});
		end_of_test();
	end
endmodule // tb_top
bind dac_host dac_host_props props (.clk, .reset_n, .chip_select_n, .write_n, .read_n, .sleep_n,
	.channel_addr_msb, .channel_addr_mid, .channel_addr_lsb, .data_out, .data_oe);
